//--- pkg/ssb_pkg.sv
// constants and types shared by both ends of the synchronous sram burst link
// Contract
// - state changes only on rising clock edge
// - clock enable high freezes state and address
// - stall during read keeps data driven
// - stall during write floats bus, no write
// - burst direction fixed by load cycle
// - every read or write continue cycle steps burst counter
// - two-bit counter wraps after four accesses
// - order select high: interleaved xor sequence
// - order select low: linear increment modulo four
// - continue-deselect only after deselect, bus floats
// - read with output enable high: dummy
// - all lane enables high: write abort
// - each lane enable gates its lane
// - any subset of lanes writable per cycle
// - device floats outputs during any write
// - controller may tie output enable low
// - outputs float at power-up
// - output enable, sleep asynchronous; rest registered
// - load low registers address; high advances
// - controller holds order select constant; here it forwards order_interleave, which the bench changes between bursts
package ssb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 18;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF  = 4'hf;

  // ----------------------------------------------------------------
  // device operating states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSB_DESEL,
    SSB_READ,
    SSB_WRITE
  } ssb_state_type;

  // next low address pair of a burst, interleaved or linear
  function automatic logic [BURST_W-1:0] ssb_burst_addr(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count,
    input logic               interleave
  );
    ssb_burst_addr = interleave ? (start ^ count) : (start + count);
  endfunction : ssb_burst_addr

endpackage : ssb_pkg

//--- pkg/ssb_link_if.sv
// link between the memory controller end and the sram device end
`timescale 1ns/100ps
interface ssb_link_if;
  import ssb_pkg::*;
  logic                         chip_sel_n;
  logic                         chip_sel_second_n;
  logic                         chip_sel_high;
  logic                         sleep_req;
  logic                         advance_load_n;
  logic                         read_write_n;
  logic [LANES-1:0]             lane_wr_en_n;
  logic                         out_en_n;
  logic                         clk_en_n;
  logic                         burst_order;
  logic [ADDR_W-1:0]            addr;
  logic [DATA_W-1:0]            ctl_data_o;
  logic                         ctl_data_oe_n;
  logic [DATA_W-1:0]            dev_data_o;
  logic                         dev_data_oe_n;
  logic [DATA_W-1:0]            ctl_data_i;
  logic [DATA_W-1:0]            dev_data_i;

  modport ctl (
    output chip_sel_n, chip_sel_second_n, chip_sel_high, sleep_req, advance_load_n,
    output read_write_n, lane_wr_en_n, out_en_n, clk_en_n, burst_order, addr,
    output ctl_data_o, ctl_data_oe_n,
    input  ctl_data_i
  );
  modport dev (
    input  chip_sel_n, chip_sel_second_n, chip_sel_high, sleep_req, advance_load_n,
    input  read_write_n, lane_wr_en_n, out_en_n, clk_en_n, burst_order, addr,
    output dev_data_o, dev_data_oe_n,
    input  dev_data_i
  );
endinterface : ssb_link_if

//--- src/ssb_device.sv
// sram device end: command decode, burst counter, lane writes, bus drive
`timescale 1ns/100ps
module ssb_device
  import ssb_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  ssb_link_if.dev    link,
  output logic [1:0] op_state,
  output logic [1:0] burst_low
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]  mem [DEPTH];
  ssb_state_type      state_r, state_nxt;
  logic [ADDR_W-1:0]  base_r, base_nxt;
  logic [BURST_W-1:0] cnt_r, cnt_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic               live;
  logic               selected;
  logic               any_lane_wr_en;
  logic [ADDR_W-1:0]  cur_addr;
  logic [ADDR_W-1:0]  acc_addr;
  logic               do_write;

  // sleep overrides clock enable entirely
  assign live           = !link.sleep_req && !link.clk_en_n;
  assign selected       = !link.chip_sel_n && !link.chip_sel_second_n
                          && link.chip_sel_high;
  assign any_lane_wr_en = link.lane_wr_en_n != LANES_OFF;
  assign cur_addr = {base_r[ADDR_W-1:BURST_W],
                     ssb_burst_addr(base_r[BURST_W-1:0], cnt_r,
                                    link.burst_order)};

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    base_nxt      = base_r;
    cnt_nxt       = cnt_r;
    acc_addr      = cur_addr;
    do_write      = 1'b0;
    if (live) begin
      if (!link.advance_load_n) begin
        cnt_nxt = BURST_ZERO;
        if (!selected) begin
          state_nxt = SSB_DESEL;
        end else begin
          base_nxt  = link.addr;
          acc_addr  = link.addr;
          state_nxt = link.read_write_n ? SSB_READ : SSB_WRITE;
          do_write  = !link.read_write_n && any_lane_wr_en;
        end
      end else if (state_r != SSB_DESEL) begin
        // direction held from the load cycle, read_write_n ignored
        cnt_nxt  = cnt_r + BURST_ONE;
        acc_addr = {base_r[ADDR_W-1:BURST_W],
                    ssb_burst_addr(base_r[BURST_W-1:0], cnt_nxt, link.burst_order)};
        do_write = (state_r == SSB_WRITE) && any_lane_wr_en;
      end
    end
    rdata_nxt = live ? mem[acc_addr] : rdata_r;
  end

  // lane-gated array write; stalled edges never write
  always_ff @(posedge mclk) begin
    if (do_write) begin
      for (int i = 0; i < LANES; i++) begin
        if (!link.lane_wr_en_n[i]) begin
          mem[acc_addr][i*LANE_W +: LANE_W] <= link.dev_data_i[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // state registers, edge-only updates
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= SSB_DESEL;
      base_r      <= '0;
      cnt_r       <= BURST_ZERO;
      rdata_r     <= '0;
    end else begin
      state_r     <= state_nxt;
      base_r      <= base_nxt;
      cnt_r       <= cnt_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bus drive: only reads with output enable low and no sleep drive
  // ----------------------------------------------------------------
  // output enable and sleep act without the clock
  assign link.dev_data_oe_n = !(state_r == SSB_READ && !link.out_en_n
                                && !link.sleep_req);
  assign link.dev_data_o    = rdata_r;
  assign op_state           = state_r;
  assign burst_low          = cnt_r;

endmodule : ssb_device

//--- src/ssb_ctrl.sv
// controller end: turns user requests into link cycles
`timescale 1ns/100ps
module ssb_ctrl
  import ssb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  ssb_link_if.ctl                link,
  input  wire logic              req_valid,
  input  wire logic              req_load,
  input  wire logic              req_sel,
  input  wire logic              req_write,
  input  wire logic [LANES-1:0]  req_lanes,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_stall,
  input  wire logic              req_sleep,
  input  wire logic              order_interleave,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data
);

  logic              wr_r, wr_nxt;
  logic              rd_r, rd_nxt;
  logic              rd_pend_r, rd_pend_nxt;
  logic              taken;
  logic              loading;

  // an idle request is a deselect load, so it ends any burst direction
  assign taken   = !req_stall && !req_sleep;
  assign loading = !req_valid || req_load;

  // direction tracks every taken load, deselects included, so a
  // continue-deselect never inherits an old read or write burst
  always_comb begin
    wr_nxt      = wr_r;
    rd_nxt      = rd_r;
    rd_pend_nxt = rd_pend_r && req_stall && !req_sleep;
    if (taken) begin
      if (loading) begin
        wr_nxt = req_valid && req_sel && req_write;
        rd_nxt = req_valid && req_sel && !req_write;
      end
      rd_pend_nxt = loading ? (req_valid && req_sel && !req_write) : rd_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      wr_r      <= wr_nxt;
      rd_r      <= rd_nxt;
      rd_pend_r <= rd_pend_nxt;
    end
  end

  // idle cycles are deselect loads so continue-deselects stay legal
  assign link.chip_sel_n        = !(req_valid && req_sel);
  assign link.chip_sel_second_n = !(req_valid && req_sel);
  assign link.chip_sel_high     = req_valid && req_sel;
  assign link.sleep_req         = req_sleep;
  assign link.advance_load_n    = req_valid && !req_load;
  assign link.read_write_n      = !req_write;
  // continues take their lanes from the loaded direction, not req_write
  assign link.lane_wr_en_n      = (loading ? req_write : wr_r) ?
                                  ~req_lanes : LANES_OFF;
  assign link.out_en_n          = 1'b0;
  assign link.clk_en_n          = req_stall;
  assign link.burst_order       = order_interleave;
  assign link.addr              = req_addr;
  assign link.ctl_data_o        = req_wdata;
  assign link.ctl_data_oe_n     = !(taken &&
                                    (loading ? (req_valid && req_sel && req_write) : wr_r));
  assign rd_valid               = rd_pend_r && !req_stall;
  assign rd_data                = link.ctl_data_i;

endmodule : ssb_ctrl

//--- verification/ssb_props.sv
// assertions on the link between the controller end and the sram device end
`timescale 1ns/100ps
module ssb_props
  import ssb_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              chip_sel_n,
  input wire logic              chip_sel_second_n,
  input wire logic              chip_sel_high,
  input wire logic              sleep_req,
  input wire logic              advance_load_n,
  input wire logic              read_write_n,
  input wire logic              out_en_n,
  input wire logic              clk_en_n,
  input wire logic              dev_data_oe_n,
  input wire logic [DATA_W-1:0] dev_data_o
);
  // ----------------------------------------
  // taken-edge decode
  // ----------------------------------------
  // an edge counts only when awake and not stalled
  wire go  = !sleep_req && !clk_en_n;
  wire sel = !chip_sel_n && !chip_sel_second_n && chip_sel_high;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; go && !advance_load_n && sel && read_write_n && !out_en_n; endsequence
  sequence s_wr; go && !advance_load_n && sel && !read_write_n; endsequence
  sequence s_ds; go && !advance_load_n && !sel; endsequence
  sequence s_go_on; go && advance_load_n; endsequence
  // sleep floats the bus at once, so each drive check lets it win
  AST_READ_DRIVES: assert property (s_rd |=> sleep_req || !dev_data_oe_n)
    else $error("read load left bus floating");
  AST_WRITE_FLOATS: assert property (s_wr |=> dev_data_oe_n)
    else $error("device drove bus after write load");
  AST_DESEL_FLOATS: assert property (s_ds |=> dev_data_oe_n)
    else $error("device drove bus after deselect");
  AST_SLEEP_FLOATS: assert property (sleep_req |-> dev_data_oe_n)
    else $error("device drove bus while asleep");
  AST_STALL_HOLDS: assert property ((clk_en_n && !sleep_req) ##1 !sleep_req |->
    $stable(dev_data_oe_n) && (dev_data_oe_n || $stable(dev_data_o)))
    else $error("stalled edge changed bus");
  AST_CONT_DESEL: assert property (s_ds ##1 s_go_on |=> dev_data_oe_n)
    else $error("continue deselect drove bus");
  AST_CONT_READ: assert property (s_rd ##1 s_go_on |=> sleep_req || !dev_data_oe_n)
    else $error("read burst continue not driven");
  AST_CONT_WRITE: assert property (s_wr ##1 s_go_on |=> dev_data_oe_n)
    else $error("write burst continue drove bus");
  AST_POWER_UP: assert property ($rose(rst_n) |-> dev_data_oe_n)
    else $error("bus driven after reset");
endmodule : ssb_props

//--- verification/testbench.sv
// self-checking bench: controller end and sram device end joined back to back
`timescale 1ns/100ps
module testbench;
  import ssb_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              req_valid, req_load, req_sel, req_write, req_stall, req_sleep;
  logic              order_interleave, rd_valid, pv = 1'b0;
  logic [1:0]        op_state, burst_low;
  logic [LANES-1:0]  req_lanes;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, pd, last_bus = '0;
  logic [DATA_W-1:0] ref_mem [64];
  int                errors = 0, compares = 0, cycles = 0;
  ssb_link_if lnk ();
  // released bus shows the inverse of its last value, never a lucky match
  wire [DATA_W-1:0] bus = !lnk.dev_data_oe_n ? lnk.dev_data_o
                        : !lnk.ctl_data_oe_n ? lnk.ctl_data_o : ~last_bus;
  assign lnk.ctl_data_i = bus;
  assign lnk.dev_data_i = bus;
  always @(posedge mclk) last_bus <= bus;
  always #4 mclk = ~mclk;
  ssb_ctrl ssb_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.ctl), .req_valid(req_valid),
    .req_load(req_load), .req_sel(req_sel), .req_write(req_write), .req_lanes(req_lanes),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_stall(req_stall), .req_sleep(req_sleep),
    .order_interleave(order_interleave), .rd_valid(rd_valid), .rd_data(rd_data));
  ssb_device ssb_device_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.dev), .op_state(op_state),
    .burst_low(burst_low));
  ssb_props ssb_props_inst (.mclk(mclk), .rst_n(rst_n), .chip_sel_n(lnk.chip_sel_n),
    .chip_sel_second_n(lnk.chip_sel_second_n), .chip_sel_high(lnk.chip_sel_high),
    .sleep_req(lnk.sleep_req), .advance_load_n(lnk.advance_load_n),
    .read_write_n(lnk.read_write_n), .out_en_n(lnk.out_en_n), .clk_en_n(lnk.clk_en_n),
    .dev_data_oe_n(lnk.dev_data_oe_n), .dev_data_o(lnk.dev_data_o));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // one link cycle; checks what the previous request put on the bus
  task automatic op(input logic v, ld, wr, st, sl, input logic [LANES-1:0] ln,
                    input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
                    input logic ev, input logic [DATA_W-1:0] ed);
    @(posedge mclk);
    {req_valid, req_load, req_sel, req_write, req_stall, req_sleep} <= {v, ld, v, wr, st, sl};
    {req_lanes, req_addr, req_wdata} <= {ln, ad, wd};
    @(negedge mclk);
    compares++;
    // a stalled cycle holds the read data back; it is delivered the cycle after
    if ((pv && !st) ? {rd_valid, rd_data} !== {1'b1, pd} : rd_valid !== 1'b0) begin
      errors++;
      $display("mismatch rd_data expected %b %h seen %b %h", pv && !st, pd, rd_valid, rd_data);
    end
    if (st && pv) begin
      compares++;
      if (lnk.dev_data_oe_n !== 1'b0 || bus !== pd) begin
        errors++;
        $display("mismatch stall_bus expected %h seen %b %h", pd, lnk.dev_data_oe_n, bus);
      end
    end
    compares++;
    if (!lnk.dev_data_oe_n && !lnk.ctl_data_oe_n) begin
      errors++;
      $display("mismatch bus_drivers expected 1 seen 2");
    end
    pv = ev;
    pd = ed;
  endtask : op
  // load plus n continues; continues flip the write input, which must not matter
  task automatic burst(input logic wr, il, input logic [ADDR_W-1:0] a,
                       input int n, stall_at, input logic [LANES-1:0] ln);
    logic [ADDR_W-1:0] ad;
    logic [DATA_W-1:0] wd;
    order_interleave <= il;
    for (int i = 0; i <= n; i++) begin
      ad = {a[ADDR_W-1:2], il ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
      wd = {{2{ln, 4'(i)}}, ad[15:0] ^ {2{ln, 4'(i)}}};
      if (i == stall_at) op(1, 0, wr, 1, 0, ln, ad, ~wd, pv, pd);
      op(1, i == 0, i == 0 ? wr : !wr, 0, 0, ln, ad, wd, !wr, ref_mem[ad[5:0]]);
      // the access taken at this op's edge is number i-1 of the burst
      if (i > 0) begin
        compares++;
        if ({op_state, burst_low} !== {wr ? 2'h2 : 2'h1, 2'(i - 1)}) begin
          errors++;
          $display("mismatch burst_state expected %h seen %h",
                   {wr ? 2'h2 : 2'h1, 2'(i - 1)}, {op_state, burst_low});
        end
      end
      for (int l = 0; l < LANES; l++)
        if (wr && ln[l]) ref_mem[ad[5:0]][l*LANE_W +: LANE_W] = wd[l*LANE_W +: LANE_W];
    end
  endtask : burst
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  // whole run is about 42 cycles; the ceiling only catches a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    {req_valid, req_load, req_sel, req_write, req_stall, req_sleep, order_interleave} = '0;
    {req_lanes, req_addr, req_wdata} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    burst(1, 0, 18'h12, 4, 2, 4'hf); // linear write past wrap, stalled
    burst(0, 0, 18'h12, 4, 3, 4'hf); // read back with stall
    op(0, 1, 0, 0, 0, 4'h0, 18'h0, 32'h0, 0, 32'h0); // deselect
    burst(1, 1, 18'h21, 3, 9, 4'hf); // interleaved write
    for (int l = 0; l < LANES; l++) burst(1, 1, 18'h20 + 18'(l), 0, 9, 4'(1 << l));
    burst(1, 1, 18'h22, 1, 9, 4'h0); // abort on load and continue
    burst(0, 1, 18'h21, 4, 9, 4'hf); // interleaved read with wrap
    op(0, 1, 0, 0, 0, 4'h0, 18'h0, 32'h0, 0, 32'h0); // deselect
    op(1, 0, 0, 0, 0, 4'h0, 18'h0, 32'h0, 0, 32'h0); // continue deselect
    op(1, 1, 0, 0, 1, 4'h0, 18'h0, 32'h0, 0, 32'h0); // sleep
    op(0, 1, 0, 0, 0, 4'h0, 18'h0, 32'h0, 0, 32'h0); // flush last check
    tally_and_finish;
  end
endmodule : testbench
